// ---- hdl/flash_self_program_control.sv ----
// Run-time flash self-programming sequencer with unlock key and processor stall
//
// How it works
// RULE1: The block can either erase one page or program two instruction words in one operation.
// RULE2: The processor stall output stays high from launch until the flash reports the operation done.
// RULE3: Writing one to control bit 15 launches the operation and hardware clears that bit at completion.
// RULE4: A program target must sit on an every-other-word boundary (low address bits 10), else it is refused.
// RULE5: Software erases the page holding the target before programming it.
// RULE6: Only a write of 0x55 then 0xaa to the key register, back to back, arms the next start.
// RULE7: The key register stores nothing readable and always reads as zero.
// RULE8: Software places two no-operation instructions after the starting instruction.
// RULE9: Software waits for completion and repeats the full sequence for every operation.
// RULE10: The high and low address registers join into one 24-bit effective target address.
// RULE11: The high register gives the upper 8 address bits and the low register the lower 16.
// RULE12: A start write not immediately preceded by the unlock pair is ignored and nothing begins.
`timescale 1ns/1ps
module flash_self_program_control
  import flash_self_program_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  input  wire logic                   key_write,
  input  wire logic [KEY_W-1:0]       key_data,
  input  wire logic                   other_write,
  input  wire logic                   addr_high_write,
  input  wire logic [ADDR_HIGH_W-1:0] addr_high_data,
  input  wire logic                   addr_low_write,
  input  wire logic [ADDR_LOW_W-1:0]  addr_low_data,
  input  wire logic                   control_write,
  input  wire logic [CTRL_W-1:0]      control_data,
  input  wire logic [WORD_W-1:0]      word0_data,
  input  wire logic [WORD_W-1:0]      word1_data,
  input  wire logic                   flash_done,
  output logic [CTRL_W-1:0]           nonvolatile_control_reg,
  output logic [ADDR_HIGH_W-1:0]      target_address_high_reg,
  output logic [ADDR_LOW_W-1:0]       target_address_low_reg,
  output logic [KEY_W-1:0]            unlock_key_read_reg,
  output logic                        cpu_stall_reg,
  output logic                        flash_start_reg,
  output logic                        flash_erase_reg,
  output logic [ADDR_W-1:0]           flash_addr_reg,
  output logic [WORD_W-1:0]           flash_wdata0_reg,
  output logic [WORD_W-1:0]           flash_wdata1_reg
);

  // ----------------------------------------------------------------
  // Unlock key tracking
  // ----------------------------------------------------------------
  key_state_t key_state_reg;
  key_state_t key_state_next;
  seq_state_t seq_state_reg;
  seq_state_t seq_state_next;
  logic       any_write;
  logic       busy;

  assign busy      = (seq_state_reg != SEQ_IDLE);
  assign any_write = key_write | other_write | addr_high_write | addr_low_write | control_write;

  // Every bus write while idle moves the key tracker, so the pair must be strictly consecutive
  always_comb begin
    key_state_next = key_state_reg;
    if (any_write && !busy) begin
      if (key_write && key_data == KEY_FIRST) begin
        key_state_next = KEY_HALF;                                 // [RULE6]
      end else if (key_write && key_data == KEY_SECOND && key_state_reg == KEY_HALF) begin
        key_state_next = KEY_UNLOCKED;                             // [RULE6]
      end else begin
        key_state_next = KEY_LOCKED;                               // [RULE6] [RULE12]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      key_state_reg <= KEY_LOCKED;
    end else if (clk_en) begin
      key_state_reg <= key_state_next;
    end
  end

  // ----------------------------------------------------------------
  // Target address registers
  // ----------------------------------------------------------------
  logic [ADDR_HIGH_W-1:0] addr_high_next;
  logic [ADDR_LOW_W-1:0]  addr_low_next;
  logic [ADDR_W-1:0]      eff_addr;

  // Effective target address built from both halves
  assign eff_addr = {target_address_high_reg, target_address_low_reg}; // [RULE10] [RULE11]

  // Writes are dropped while busy; the stalled processor cannot issue them anyway
  always_comb begin
    addr_high_next = target_address_high_reg;
    addr_low_next  = target_address_low_reg;
    if (!busy) begin
      if (addr_high_write) begin
        addr_high_next = addr_high_data;                            // [RULE11]
      end
      if (addr_low_write) begin
        addr_low_next = addr_low_data;                              // [RULE11]
      end
    end
  end

  // Address halves are plain software registers, cleared by reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      target_address_high_reg <= '0;
      target_address_low_reg  <= '0;
    end else if (clk_en) begin
      target_address_high_reg <= addr_high_next;
      target_address_low_reg  <= addr_low_next;
    end
  end

  // ----------------------------------------------------------------
  // Control register and operation sequencer
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_next;
  logic              stall_next;
  logic              launch_ok;

  // Start is honoured only with the key armed and, for program, an aligned target
  assign launch_ok = control_write && !busy && control_data[START_BIT]
                   && key_state_reg == KEY_UNLOCKED                  // [RULE12]
                   && (control_data[ERASE_BIT] || eff_addr[1:0] == PROG_ALIGN); // [RULE4]

  // The start bit doubles as the busy flag, so it is set and cleared together with the stall.
  // A start refused while idle still stores the other control bits; software sees bit 15 read back low.
  always_comb begin
    ctrl_next      = nonvolatile_control_reg;
    seq_state_next = seq_state_reg;
    stall_next     = cpu_stall_reg;
    if (!busy && control_write) begin
      ctrl_next            = control_data;
      ctrl_next[START_BIT] = launch_ok;                             // [RULE12]
    end
    unique case (seq_state_reg)
      SEQ_IDLE: begin
        if (launch_ok) begin
          seq_state_next = SEQ_LAUNCH;                              // [RULE3]
          stall_next     = 1'b1;                                    // [RULE2]
        end
      end
      // Completion is ignored while the start pulse is still out to the macro
      SEQ_LAUNCH: begin
        seq_state_next = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (flash_done) begin
          seq_state_next       = SEQ_IDLE;
          stall_next           = 1'b0;                              // [RULE2]
          ctrl_next[START_BIT] = 1'b0;                              // [RULE3]
        end
      end
      // The unused code falls back to idle so the processor can never stay stalled
      default: begin
        seq_state_next       = SEQ_IDLE;
        stall_next           = 1'b0;
        ctrl_next[START_BIT] = 1'b0;
      end
    endcase
  end

  // Control readback, sequencer state and stall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nonvolatile_control_reg <= CTRL_RESET;
      seq_state_reg           <= SEQ_IDLE;
      cpu_stall_reg           <= 1'b0;
    end else if (clk_en) begin
      nonvolatile_control_reg <= ctrl_next;
      seq_state_reg           <= seq_state_next;
      cpu_stall_reg           <= stall_next;
    end
  end

  // ----------------------------------------------------------------
  // Flash macro strobe and operands
  // ----------------------------------------------------------------
  logic              start_next;
  logic              erase_next;
  logic [ADDR_W-1:0] faddr_next;
  logic [WORD_W-1:0] wd0_next;
  logic [WORD_W-1:0] wd1_next;

  // Operands are captured once at launch and then held, so they never move under a running operation
  always_comb begin
    start_next = 1'b0;
    erase_next = flash_erase_reg;
    faddr_next = flash_addr_reg;
    wd0_next   = flash_wdata0_reg;
    wd1_next   = flash_wdata1_reg;
    if (launch_ok) begin
      start_next = 1'b1;                                            // [RULE3]
      erase_next = control_data[ERASE_BIT];                         // [RULE1]
      faddr_next = eff_addr;                                        // [RULE10]
      wd0_next   = word0_data;                                      // [RULE1]
      wd1_next   = word1_data;                                      // [RULE1]
    end
  end

  // Start is a one-cycle pulse; the rest stands until the next accepted start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_start_reg  <= 1'b0;
      flash_erase_reg  <= 1'b0;
      flash_addr_reg   <= '0;
      flash_wdata0_reg <= '0;
      flash_wdata1_reg <= '0;
    end else if (clk_en) begin
      flash_start_reg  <= start_next;
      flash_erase_reg  <= erase_next;
      flash_addr_reg   <= faddr_next;
      flash_wdata0_reg <= wd0_next;
      flash_wdata1_reg <= wd1_next;
    end
  end

  // ----------------------------------------------------------------
  // Key readback
  // ----------------------------------------------------------------
  // The key itself is never stored where a read could reach it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      unlock_key_read_reg <= KEY_READ;
    end else if (clk_en) begin
      unlock_key_read_reg <= KEY_READ;                              // [RULE7]
    end
  end

endmodule : flash_self_program_control

// ---- hdl/flash_self_program_pkg.sv ----
// Constants shared by the flash self-programming sequencer
package flash_self_program_pkg;

  // ----------------------------------------------------------------
  // Address and data widths
  // ----------------------------------------------------------------
  localparam int ADDR_HIGH_W = 8;
  localparam int ADDR_LOW_W  = 16;
  localparam int ADDR_W      = ADDR_HIGH_W + ADDR_LOW_W;
  localparam int WORD_W      = 24;
  localparam int CTRL_W      = 16;
  localparam int KEY_W       = 8;

  // ----------------------------------------------------------------
  // Control register field positions and reset value
  // ----------------------------------------------------------------
  localparam int                START_BIT  = 15;
  localparam int                ERASE_BIT  = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Unlock key values and program alignment
  // ----------------------------------------------------------------
  localparam logic [KEY_W-1:0] KEY_FIRST   = 8'h55;
  localparam logic [KEY_W-1:0] KEY_SECOND  = 8'haa;
  localparam logic [1:0]       PROG_ALIGN  = 2'h2;
  localparam logic [KEY_W-1:0] KEY_READ    = 8'h00;

  // ----------------------------------------------------------------
  // State encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KEY_LOCKED   = 2'b00,
    KEY_HALF     = 2'b01,
    KEY_UNLOCKED = 2'b10
  } key_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_LAUNCH = 2'b01,
    SEQ_WAIT   = 2'b10
  } seq_state_t;

endpackage : flash_self_program_pkg

// ---- test/flash_self_program_monitor.sv ----
// Port-level assertion checker for the flash self-programming sequencer
`timescale 1ns/1ps
module flash_self_program_monitor
  import flash_self_program_pkg::*;
(
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   clk_en,
  input wire logic                   flash_done,
  input wire logic [CTRL_W-1:0]      nonvolatile_control_reg,
  input wire logic [ADDR_HIGH_W-1:0] target_address_high_reg,
  input wire logic [ADDR_LOW_W-1:0]  target_address_low_reg,
  input wire logic [KEY_W-1:0]       unlock_key_read_reg,
  input wire logic                   cpu_stall_reg,
  input wire logic                   flash_start_reg,
  input wire logic                   flash_erase_reg,
  input wire logic [ADDR_W-1:0]      flash_addr_reg
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Launch is a single pulse followed by a held stall
  sequence s_launch;
    flash_start_reg ##1 (!flash_start_reg && cpu_stall_reg);
  endsequence
  property p_key_read; unlock_key_read_reg == KEY_READ; endproperty
  property p_start_pulse; flash_start_reg && clk_en |-> s_launch; endproperty
  property p_start_busy; flash_start_reg |-> cpu_stall_reg && nonvolatile_control_reg[START_BIT]; endproperty
  property p_busy_bit; cpu_stall_reg == nonvolatile_control_reg[START_BIT]; endproperty
  property p_release; cpu_stall_reg && !flash_start_reg && flash_done && clk_en |=> !cpu_stall_reg; endproperty
  property p_hold; cpu_stall_reg && !flash_done |=> cpu_stall_reg; endproperty
  property p_addr_join; flash_start_reg |-> flash_addr_reg == {target_address_high_reg, target_address_low_reg}; endproperty
  property p_align; flash_start_reg && !flash_erase_reg |-> flash_addr_reg[1:0] == PROG_ALIGN; endproperty
  property p_rise; $rose(cpu_stall_reg) |-> flash_start_reg; endproperty
  a_key_read: assert property (p_key_read) else $error("key readback not zero");
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse wrong");
  a_start_busy: assert property (p_start_busy) else $error("start without stall");
  a_busy_bit: assert property (p_busy_bit) else $error("start bit and stall differ");
  a_release: assert property (p_release) else $error("stall not released");
  a_hold: assert property (p_hold) else $error("stall dropped early");
  a_addr_join: assert property (p_addr_join) else $error("target address wrong");
  a_align: assert property (p_align) else $error("misaligned program");
  a_rise: assert property (p_rise) else $error("stall without launch");
endmodule : flash_self_program_monitor

bind flash_self_program_control flash_self_program_monitor u_flash_self_program_monitor (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the flash self-programming sequencer
`timescale 1ns/1ps
module tb_top;
  import flash_self_program_pkg::*;
  logic clk = 0, reset_n = 0, clk_en = 1, key_write = 0, other_write = 0, addr_high_write = 0;
  logic addr_low_write = 0, control_write = 0, flash_done = 0;
  logic [7:0] key_data = 0, addr_high_data = 0, hr, ur, op_h;
  logic [15:0] addr_low_data = 0, control_data = 0, nvc, lr, op_l;
  logic [23:0] word0_data = 0, word1_data = 0, fa, w0, w1;
  logic stall, fs, fe;
  int num_errors = 0, num_checks = 0;
  flash_self_program_control u_flash_self_program_control (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .key_write(key_write), .key_data(key_data), .other_write(other_write), .addr_high_write(addr_high_write),
    .addr_high_data(addr_high_data), .addr_low_write(addr_low_write), .addr_low_data(addr_low_data),
    .control_write(control_write), .control_data(control_data), .word0_data(word0_data),
    .word1_data(word1_data), .flash_done(flash_done), .nonvolatile_control_reg(nvc),
    .target_address_high_reg(hr), .target_address_low_reg(lr), .unlock_key_read_reg(ur), .cpu_stall_reg(stall),
    .flash_start_reg(fs), .flash_erase_reg(fe), .flash_addr_reg(fa), .flash_wdata0_reg(w0),
    .flash_wdata1_reg(w1));
  // ----------------------------------------------------------------
  // Clock, compare, closing
  // ----------------------------------------------------------------
  always #5 clk = ~clk;
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic finish_test;
    if (num_errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test
  // One bus write: a quiet cycle, then strobe for one cycle
  task automatic wr(input int k, input logic [15:0] d);
    @(posedge clk) #1;
    case (k)
      0: begin key_write = 1; key_data = d[7:0]; end
      1: other_write = 1;
      2: begin addr_high_write = 1; addr_high_data = d[7:0]; end
      3: begin addr_low_write = 1; addr_low_data = d; end
      default: begin control_write = 1; control_data = d; end
    endcase
    @(posedge clk) #1;
    {key_write, other_write, addr_high_write, addr_low_write, control_write} = '0;
  endtask : wr
  // Start only with an unbroken key pair and a legal target
  function automatic logic exp_go(input bit e, input bit good, input bit brk, input logic [1:0] a);
    return good && !brk && (e || a == PROG_ALIGN);
  endfunction : exp_go
  // Full sequence: address, key pair, start, then completion; same keeps the last page
  task automatic op(input bit e, input bit good, input bit brk, input logic [1:0] lo2, input bit same);
    logic go;
    bit fz;
    if (!same) begin
      op_h = 8'($urandom);
      op_l[15:2] = 14'($urandom);
    end
    op_l[1:0] = lo2;
    word0_data = 24'($urandom);
    word1_data = 24'($urandom);
    wr(2, op_h);
    wr(3, op_l);
    chk("adrh", op_h, hr);
    chk("adrl", op_l, lr);
    wr(0, KEY_FIRST);
    if (brk) wr(1, 0);
    wr(0, good ? KEY_SECOND : KEY_FIRST);
    go = exp_go(e, good, brk, lo2);
    wr(4, {1'b1, e, 14'h0});
    chk("start", go, fs);
    chk("stall", go, stall);
    chk("busy", go, nvc[15]);
    if (go) begin
      chk("addr", {op_h, op_l}, fa);
      chk("erase", e, fe);
      chk("w0", word0_data, w0);
      chk("w1", word1_data, w1);
      repeat (2) @(posedge clk); // two idle instruction slots after the start
      wr(2, ~op_h);
      chk("hold", op_h, hr);
      repeat ($urandom_range(1, 4)) @(posedge clk);
      fz = 1'($urandom);
      #1 flash_done = 1;
      clk_en = !fz;
      @(posedge clk) #1;
      chk("freeze", fz, stall);
      clk_en = 1;
      if (fz) begin
        @(posedge clk) #1;
      end
      flash_done = 0;
      chk("done", 0, {stall, nvc[15]});
    end
    chk("keyrd", 0, ur);
  endtask : op
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
  initial begin
    void'($urandom(52));
    repeat (8) @(posedge clk);
    #1 reset_n = 1;
    chk("rst", 0, {nvc, stall, fs});
    op(1, 1, 0, 2'h2, 0); // erase the page first
    op(0, 1, 0, 2'h2, 1); // then program two words inside it
    op(1, 1, 0, 2'h1, 0);
    op(0, 1, 0, 2'h3, 0);
    op(0, 0, 0, 2'h2, 0);
    op(1, 1, 1, 2'h0, 0);
    repeat (30) op(1'($urandom), $urandom_range(0, 3) != 0, $urandom_range(0, 5) == 0, 2'($urandom), 1'($urandom));
    finish_test();
  end
endmodule : tb_top
